// >>> src/gpx_consts.vh
// Constants for the 16-bit I/O expander: register indices, slave address base,
// reset values and field positions. Definitions only.
`ifndef GPX_CONSTS_VH
`define GPX_CONSTS_VH

// Register indices of the port register set (byte address = 4 * index)
`define GPX_IDX_IN0 4'h0
`define GPX_IDX_IN1 4'h1
`define GPX_IDX_OUT0 4'h2
`define GPX_IDX_OUT1 4'h3
`define GPX_IDX_INV0 4'h4
`define GPX_IDX_INV1 4'h5
`define GPX_IDX_CFG0 4'h6
`define GPX_IDX_CFG1 4'h7
// Command pointer, pointed data window, strapped address, interrupts
`define GPX_IDX_CMD 4'h8
`define GPX_IDX_DATA 4'h9
`define GPX_IDX_SADDR 4'hA
`define GPX_IDX_IRQ_STAT 4'hB
`define GPX_IDX_IRQ_MASK 4'hC
`define GPX_IDX_LAST 4'hC

// Reset values
`define GPX_RST_OUT 8'hFF
`define GPX_RST_INV 8'h00
`define GPX_RST_CFG 8'hFF
`define GPX_RST_PTR 3'h0

// Fixed upper part of the 7-bit slave address (value is arbitrary)
`define GPX_SADDR_BASE 4'h4

// Command register fields
`define GPX_CMD_PTR_LSB 0
`define GPX_CMD_PTR_MSB 2
`define GPX_CMD_ADR_LSB 8
`define GPX_CMD_ADR_MSB 14

// Interrupt status bits
`define GPX_IRQ_W 3
`define GPX_IRQ_CHG0 0
`define GPX_IRQ_CHG1 1
`define GPX_IRQ_BADADR 2

`endif

// >>> src/gpx_port.v
// One 8-pin port: pin drive, polarity-corrected input value, and the
// captured copy that the change alert is compared against.
// Assumes pin levels are synchronous to sys_clk_in.
`timescale 1ns/1ps

module gpx_port (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire [7:0] pins_in,
  input wire [7:0] out_reg_in,
  input wire [7:0] inv_reg_in,
  input wire [7:0] cfg_reg_in,
  input wire capture_in,
  output wire [7:0] pins_out,
  output wire [7:0] pins_oe_out,
  output wire [7:0] in_val_out,
  output wire alert_out
);

  reg [7:0] captured;
  reg primed;

  // Bit n of every register maps to pin n
  assign in_val_out = pins_in ^ inv_reg_in;
  // A set config bit leaves the pin undriven
  assign pins_oe_out = ~cfg_reg_in;
  assign pins_out = out_reg_in;
  assign alert_out = primed & (|(in_val_out ^ captured));

  // Snapshot taken right after reset and at each read of the input register
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      captured <= 8'h00;
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
      if (!primed || capture_in) begin
        captured <= in_val_out;
      end
    end
  end

endmodule // gpx_port

// >>> src/gpx_irq.v
// Sticky interrupt status with write-one-to-clear and a mask.
// Assumes event inputs are single-cycle or level, synchronous to clock.
`timescale 1ns/1ps
`include "gpx_consts.vh"

module gpx_irq (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire [`GPX_IRQ_W-1:0] event_in,
  input wire stat_wr_in,
  input wire mask_wr_in,
  input wire [`GPX_IRQ_W-1:0] wdata_in,
  output reg [`GPX_IRQ_W-1:0] stat_out,
  output reg [`GPX_IRQ_W-1:0] mask_out,
  output wire irq_out
);

  assign irq_out = |(stat_out & mask_out);

  // A new event wins over a clear in the same cycle
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_out <= {`GPX_IRQ_W{1'b0}};
      mask_out <= {`GPX_IRQ_W{1'b0}};
    end else begin
      if (stat_wr_in) begin
        stat_out <= (stat_out & ~wdata_in) | event_in;
      end else begin
        stat_out <= stat_out | event_in;
      end
      if (mask_wr_in) begin
        mask_out <= wdata_in;
      end
    end
  end

endmodule // gpx_irq

// >>> src/gpx_expander.v
// Top of the 16-bit I/O expander: APB register slave, command pointer,
// port register pairs, change alert and interrupt.
// Assumes an APB master on sys_clk_in and synchronous pin inputs.
//
// Overview of operation
// - The alert is active while any pin differs from its captured input value.
// - The alert is open-drain and active low: driven low or released.
// - Reset loads every register default and returns control to idle.
// - After reset all sixteen pins are undriven inputs.
// - The slave address is a fixed part plus three straps; commands must match it.
// - Four pairs of 8-bit registers: direction, input, output, inversion.
// - Pin n of each port maps to bit n of that port's registers.
// - Output pins hold the last written output value until rewritten or reset.
// - A command byte sets a write-only pointer whose low three bits pick a register.
// - Input registers show the pin levels in any direction and ignore writes.
// - An inversion bit of one inverts that pin in the input register.
// - A direction bit of one makes an input, zero drives the output register.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "gpx_consts.vh"

module gpx_expander (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire addr_strap_0_in,
  input wire addr_strap_1_in,
  input wire addr_strap_2_in,
  input wire [7:0] low_port_pins_in,
  output wire [7:0] low_port_pins_out,
  output wire [7:0] low_port_pins_oe_out,
  input wire [7:0] high_port_pins_in,
  output wire [7:0] high_port_pins_out,
  output wire [7:0] high_port_pins_oe_out,
  input wire alert_n_in,
  output wire alert_n_out,
  output wire alert_n_oe_out,
  output wire irq_out
);

  reg [7:0] out0;
  reg [7:0] out1;
  reg [7:0] inv0;
  reg [7:0] inv1;
  reg [7:0] cfg0;
  reg [7:0] cfg1;
  reg [2:0] ptr;
  reg [6:0] strap_addr;
  reg alert0_d;
  reg alert1_d;

  wire [7:0] in0;
  wire [7:0] in1;
  wire alert0;
  wire alert1;
  wire [3:0] idx;
  wire mapped;
  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire rd_acc;
  wire [3:0] eff_idx;
  wire port_sel;
  wire [2:0] port_idx;
  wire [`GPX_IRQ_W-1:0] irq_stat;
  wire [`GPX_IRQ_W-1:0] irq_mask;
  wire [`GPX_IRQ_W-1:0] irq_events;
  wire cmd_wr;
  wire cmd_match;

  // Byte address is four times the register index
  assign idx = paddr_in[5:2];
  assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in[7:6] == 2'b00) &&
                  (idx <= `GPX_IDX_LAST);
  assign setup_ph = psel_in & ~penable_in;
  assign access_ph = psel_in & penable_in;
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph & ~mapped;
  assign wr_acc = access_ph & pwrite_in & mapped;
  assign rd_acc = access_ph & ~pwrite_in & mapped;

  // The data window reaches the register chosen by the pointer
  assign eff_idx = (idx == `GPX_IDX_DATA) ? {1'b0, ptr} : idx;
  assign port_sel = (eff_idx <= `GPX_IDX_CFG1);
  assign port_idx = eff_idx[2:0];

  // Byte read of one of the eight port registers
  function [7:0] port_byte;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: port_byte = in0;
        3'h1: port_byte = in1;
        3'h2: port_byte = out0;
        3'h3: port_byte = out1;
        3'h4: port_byte = inv0;
        3'h5: port_byte = inv1;
        3'h6: port_byte = cfg0;
        3'h7: port_byte = cfg1;
        default: port_byte = 8'h00;
      endcase
    end
  endfunction

  // Write strobe for one port register index
  function port_wr;
    input [2:0] sel;
    begin
      port_wr = wr_acc && port_sel && (port_idx == sel);
    end
  endfunction

  // Strapped address, resampled from the straps on every clock after reset release
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_addr <= 7'h00;
    end else begin
      strap_addr <= {`GPX_SADDR_BASE, addr_strap_2_in, addr_strap_1_in,
                     addr_strap_0_in};
    end
  end

  // Command write: address field must match the strapped address
  assign cmd_wr = wr_acc && (idx == `GPX_IDX_CMD);
  assign cmd_match = (pwdata_in[`GPX_CMD_ADR_MSB:`GPX_CMD_ADR_LSB] ==
                      strap_addr);

  // Register file; input registers have no storage and take no writes
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out0 <= `GPX_RST_OUT;
      out1 <= `GPX_RST_OUT;
      inv0 <= `GPX_RST_INV;
      inv1 <= `GPX_RST_INV;
      cfg0 <= `GPX_RST_CFG;
      cfg1 <= `GPX_RST_CFG;
      ptr <= `GPX_RST_PTR;
    end else begin
      if (cmd_wr && cmd_match) begin
        ptr <= pwdata_in[`GPX_CMD_PTR_MSB:`GPX_CMD_PTR_LSB];
      end
      if (port_wr(3'h2)) begin
        out0 <= pwdata_in[7:0];
      end
      if (port_wr(3'h3)) begin
        out1 <= pwdata_in[7:0];
      end
      if (port_wr(3'h4)) begin
        inv0 <= pwdata_in[7:0];
      end
      if (port_wr(3'h5)) begin
        inv1 <= pwdata_in[7:0];
      end
      if (port_wr(3'h6)) begin
        cfg0 <= pwdata_in[7:0];
      end
      if (port_wr(3'h7)) begin
        cfg1 <= pwdata_in[7:0];
      end
    end
  end

  // Read data is latched in the setup cycle and stands through access
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      if (!mapped) begin
        prdata_out <= 32'h0000_0000;
      end else if (port_sel) begin
        prdata_out <= {24'h00_0000, port_byte(port_idx)};
      end else begin
        case (idx)
          `GPX_IDX_SADDR: prdata_out <= {25'h000_0000, strap_addr};
          `GPX_IDX_IRQ_STAT: prdata_out <= {29'h0000_0000, irq_stat};
          `GPX_IDX_IRQ_MASK: prdata_out <= {29'h0000_0000, irq_mask};
          default: prdata_out <= 32'h0000_0000; // Pointer is write-only
        endcase
      end
    end
  end

  gpx_port u_port0 (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .pins_in(low_port_pins_in),
    .out_reg_in(out0),
    .inv_reg_in(inv0),
    .cfg_reg_in(cfg0),
    .capture_in(rd_acc && (eff_idx == `GPX_IDX_IN0)),
    .pins_out(low_port_pins_out),
    .pins_oe_out(low_port_pins_oe_out),
    .in_val_out(in0),
    .alert_out(alert0)
  );

  gpx_port u_port1 (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .pins_in(high_port_pins_in),
    .out_reg_in(out1),
    .inv_reg_in(inv1),
    .cfg_reg_in(cfg1),
    .capture_in(rd_acc && (eff_idx == `GPX_IDX_IN1)),
    .pins_out(high_port_pins_out),
    .pins_oe_out(high_port_pins_oe_out),
    .in_val_out(in1),
    .alert_out(alert1)
  );

  // Alert pin: pulled low while asserted, released otherwise
  assign alert_n_out = 1'b0;
  assign alert_n_oe_out = alert0 | alert1;

  // Change events on the rising edge of each port's alert
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alert0_d <= 1'b0;
      alert1_d <= 1'b0;
    end else begin
      alert0_d <= alert0;
      alert1_d <= alert1;
    end
  end

  assign irq_events = {cmd_wr & ~cmd_match, alert1 & ~alert1_d,
                       alert0 & ~alert0_d};

  gpx_irq u_irq (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .event_in(irq_events),
    .stat_wr_in(wr_acc && (idx == `GPX_IDX_IRQ_STAT)),
    .mask_wr_in(wr_acc && (idx == `GPX_IDX_IRQ_MASK)),
    .wdata_in(pwdata_in[`GPX_IRQ_W-1:0]),
    .stat_out(irq_stat),
    .mask_out(irq_mask),
    .irq_out(irq_out)
  );

endmodule // gpx_expander

// >>> dv/gpx_pin_env.sv
// Board model around the expander: pin drivers and alert pull-up.
// Assumes outside pin levels come from the bench.
`timescale 1ns/1ps
module gpx_pin_env (
  input wire [15:0] ext_in,
  input wire [15:0] drv_in,
  input wire [15:0] oe_in,
  input wire alert_oe_in,
  input wire alert_drv_in,
  output wire [15:0] lvl_out,
  output wire alert_n_out
);
  // Driven bits follow the expander, the rest the outside world
  assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_in);
  // Pull-up sets the idle level of the released line
  assign alert_n_out = alert_oe_in ? alert_drv_in : 1'b1;
endmodule // gpx_pin_env

// >>> dv/gpx_expander_monitor.sv
// Checker on the expander top ports.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
module gpx_mon (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [7:0] low_port_pins_in,
  input wire [7:0] high_port_pins_in,
  input wire [7:0] low_port_pins_out,
  input wire [7:0] high_port_pins_out,
  input wire [7:0] low_port_pins_oe_out,
  input wire [7:0] high_port_pins_oe_out,
  input wire alert_n_out,
  input wire alert_n_oe_out,
  input wire irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_wr(a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  sequence s_rd(a);
    psel_in && penable_in && !pwrite_in && paddr_in == a;
  endsequence
  sequence s_calm;
    $stable(low_port_pins_in) && $stable(high_port_pins_in);
  endsequence
  property p_rst_in;
    $rose(arst_n_in) |-> !low_port_pins_oe_out && !high_port_pins_oe_out;
  endproperty
  property p_rst_val;
    $rose(arst_n_in) |-> low_port_pins_out == 8'hFF &&
      high_port_pins_out == 8'hFF && !irq_out;
  endproperty
  property p_od;
    alert_n_out == 1'b0;
  endproperty
  property p_cfg;
    s_wr(8'h18) |=> low_port_pins_oe_out == ~$past(pwdata_in[7:0]);
  endproperty
  property p_out;
    s_wr(8'h08) |=> low_port_pins_out == $past(pwdata_in[7:0]);
  endproperty
  property p_hold;
    !(psel_in && penable_in) |=>
      $stable(low_port_pins_out) && $stable(high_port_pins_out);
  endproperty
  property p_alert;
    $past(arst_n_in) && !(psel_in && penable_in) ##1 s_calm
      |-> $stable(alert_n_oe_out);
  endproperty
  property p_clr;
    s_rd(8'h00) ##1 s_calm [*3] ##0 s_rd(8'h04) ##1 s_calm
      |-> !alert_n_oe_out;
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("pins driven");
  a_rst_val: assert property (p_rst_val) else $error("bad reset");
  a_od: assert property (p_od) else $error("alert drives high");
  a_cfg: assert property (p_cfg) else $error("bad direction");
  a_out: assert property (p_out) else $error("bad drive");
  a_hold: assert property (p_hold) else $error("drive moved");
  a_alert: assert property (p_alert) else $error("alert moved");
  a_clr: assert property (p_clr) else $error("alert stuck");
endmodule // gpx_mon
bind gpx_expander gpx_mon u_mon (.sys_clk_in(sys_clk_in),
  .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .low_port_pins_in(low_port_pins_in),
  .high_port_pins_in(high_port_pins_in),
  .low_port_pins_out(low_port_pins_out),
  .high_port_pins_out(high_port_pins_out),
  .low_port_pins_oe_out(low_port_pins_oe_out),
  .high_port_pins_oe_out(high_port_pins_oe_out),
  .alert_n_out(alert_n_out), .alert_n_oe_out(alert_n_oe_out),
  .irq_out(irq_out));

// >>> dv/gpx_expander_bench.sv
// Self-checking bench: APB master, pin board, random pin levels.
// Assumes the design, checker and board are compiled first.
`timescale 1ns/1ps
`include "gpx_consts.vh"
module gpx_expander_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg er = 1'b0;
  reg [7:0] pa = 8'h00;
  reg [31:0] pwd = 32'h0;
  reg [31:0] rd = 32'h0;
  reg [2:0] strap = 3'h0;
  reg [15:0] ext = 16'h0;
  reg [7:0] v;
  reg [7:0] w;
  wire [31:0] prd;
  wire rdy, err, ao, aoe, al_n, irq;
  wire [15:0] drv, oe, lvl;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  gpx_expander u_gpx_expander (.sys_clk_in(clk), .arst_n_in(rst_n),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .addr_strap_0_in(strap[0]),
    .addr_strap_1_in(strap[1]), .addr_strap_2_in(strap[2]),
    .low_port_pins_in(lvl[7:0]), .low_port_pins_out(drv[7:0]),
    .low_port_pins_oe_out(oe[7:0]), .high_port_pins_in(lvl[15:8]),
    .high_port_pins_out(drv[15:8]), .high_port_pins_oe_out(oe[15:8]),
    .alert_n_in(al_n), .alert_n_out(ao), .alert_n_oe_out(aoe),
    .irq_out(irq));
  gpx_pin_env u_gpx_pin_env (.ext_in(ext), .drv_in(drv), .oe_in(oe),
    .alert_oe_in(aoe), .alert_drv_in(ao), .lvl_out(lvl),
    .alert_n_out(al_n));
  initial forever #2.5 clk = ~clk;
  task complete_run;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  function [31:0] exp_in(input [7:0] p, input [7:0] n);
    exp_in = {24'h0, p ^ n};
  endfunction
  task apb(input w_in, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1'b1;
      pwr <= w_in;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20)
        num_errors = num_errors + 1;
      rd = prd;
      er = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    #100000;
    num_errors = num_errors + 1;
    complete_run;
  end
  initial begin
    i = $urandom(22784);
    strap <= $urandom;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("oe", 32'h0, {16'h0, oe});
    chk("drive", 32'hFFFF, {16'h0, drv});
    for (i = 2; i < 8; i = i + 1) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("default", (i == 4 || i == 5) ? 32'h0 : 32'hFF, rd);
    end
    for (i = 0; i < 16; i = i + 1) begin
      v = $urandom;
      w = $urandom;
      ext <= (i < 8) ? 16'h0101 << i : 16'($urandom);
      apb(1'b1, 8'h10, {24'h0, v});
      apb(1'b1, 8'h14, {24'h0, w});
      apb(1'b1, 8'h00, 32'hFF);
      apb(1'b0, 8'h00, 32'h0);
      chk("in0", exp_in(ext[7:0], v), rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("in1", exp_in(ext[15:8], w), rd);
    end
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    v = $urandom;
    w = $urandom;
    apb(1'b1, 8'h18, {24'h0, v});
    apb(1'b1, 8'h08, {24'h0, w});
    chk("oe0", {24'h0, ~v}, {24'h0, oe[7:0]});
    chk("drive0", {24'h0, w}, {24'h0, drv[7:0]});
    apb(1'b0, 8'h00, 32'h0);
    chk("in0 out", exp_in((w & ~v) | (ext[7:0] & v), 8'h0), rd);
    apb(1'b1, 8'h18, 32'hFF);
    apb(1'b0, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("alert idle", 32'h1, {31'h0, al_n});
    ext <= ext ^ 16'h0100;
    @(posedge clk);
    chk("alert set", 32'h0, {31'h0, al_n});
    ext <= ext ^ 16'h0100;
    @(posedge clk);
    chk("alert back", 32'h1, {31'h0, al_n});
    ext <= ext ^ 16'h0001;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk("alert read", 32'h1, {31'h0, al_n});
    apb(1'b1, 8'h20, {17'h0, `GPX_SADDR_BASE, strap, 8'h03});
    v = $urandom;
    apb(1'b1, 8'h24, {24'h0, v});
    apb(1'b0, 8'h0C, 32'h0);
    chk("pointed", {24'h0, v}, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("saddr", {25'h0, `GPX_SADDR_BASE, strap}, rd);
    apb(1'b1, 8'h2C, 32'h7);
    apb(1'b1, 8'h30, 32'h4);
    apb(1'b1, 8'h20, {17'h0, `GPX_SADDR_BASE, ~strap, 8'h02});
    apb(1'b0, 8'h24, 32'h0);
    chk("pointer kept", {24'h0, v}, rd);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h2C, 32'h4);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h34, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    complete_run;
  end
endmodule // gpx_expander_bench
